// ==== bench/gpf_formatter_bench.sv ====
// self-checking bench for the report packet formatter
`timescale 1ns/1ps
module gpf_formatter_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [9:0] adr = 10'h000;
    logic [31:0] wd = 32'h0000_0000;
    logic [31:0] rd;
    logic ack;
    logic fix = 1'b0;
    logic srst = 1'b0;
    logic rv = 1'b0;
    logic [7:0] rc = 8'h00;
    logic bb = 1'b0;
    logic ant = 1'b0;
    logic rdy;
    logic vld;
    gpf_pkg::gpf_byte_type ob;
    logic [7:0] dsel;
    logic ura;
    logic [31:0] mem [0:47];
    logic [7:0] p[$];
    logic [7:0] e[$];
    logic [31:0] q;
    logic [31:0] lv;
    int seed = 27185;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int hcnt = 0;
    int n;

    always #5 clk = ~clk;

    gpf_formatter #(.HEALTH_PERIOD_CYC(200)) dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(4'hF), .dat_i(wd), .dat_o(rd), .ack_o(ack), .fix_done_i(fix), .soft_reset_i(srst),
        .req_valid_i(rv), .req_code_i(rc), .battery_backed_memory_fail_i(bb), .antenna_fault_i(ant),
        .out_ready_i(rdy), .out_valid_o(vld), .out_o(ob), .datum_sel_o(dsel), .use_ref_alt_o(ura));
    gpf_host_model host (.clk_i(clk), .rst_i(rst), .out_valid_i(vld), .out_i(ob), .out_ready_o(rdy));

    task automatic conclude;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb

    task automatic rq(input logic [7:0] c);
        rc <= c;
        rv <= 1'b1;
        @(posedge clk);
        rv <= 1'b0;
    endtask : rq

    task automatic take(input logic [7:0] code);
        gpf_pkg::gpf_byte_type b;
        p.delete();
        forever begin
            while (host.got.size() == 0)
                @(posedge clk);
            b = host.got.pop_front();
            if (p.size() == 0)
                chk("first", b.first, 1);
            p.push_back(b.data);
            if (b.last === 1'b1) begin
                if (b.code === code)
                    return;
                if (b.code === 8'h46)
                    hcnt++;
                p.delete();
            end
        end
    endtask : take

    task automatic putw(input logic [31:0] w, input int k);
        for (int i = 0; i < k; i++)
            e.push_back(w[31-8*i -: 8]);
    endtask : putw

    task automatic cmp(input string nm);
        chk(nm, p.size(), e.size());
        foreach (e[i])
            chk(nm, p[i], e[i]);
        e.delete();
    endtask : cmp

    task automatic quiet;
        repeat (40) @(posedge clk);
        while (vld !== 1'b0)
            @(posedge clk);
        host.got.delete();
    endtask : quiet

    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            conclude();
        end
    end

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        take(8'h45);
        chk("ver len", p.size(), 10);
        take(8'h46);
        take(8'h4B);
        take(8'h4A);
        chk("start len", p.size(), 20);
        chk("start tof", p[16][7], 1);
        chk("datum", dsel, 0);
        wb(0, 10'h000, 0);
        chk("ctrl reset", q, 1);
        wb(0, 10'h004, 0);
        chk("status reset", q, 1);
        wb(1, 10'h040, 32'hFFFF_FFFF);
        wb(0, 10'h040, 0);
        chk("unmapped", q, 0);
        for (int i = 0; i < 48; i++) begin
            mem[i] = $random(seed);
            if (i >= 24 && i % 3 == 0)
                mem[i][9] = mem[i][9] | mem[i][8];
            wb(1, 10'h100 | 10'(i * 4), mem[i]);
        end
        rq(8'h1F);
        take(8'h45);
        for (int i = 12; i < 15; i++)
            putw(mem[i], i < 14 ? 4 : 2);
        cmp("version");
        for (int i = 0; i < 4; i++) begin
            wb(1, 10'h000, 32'h3 | (i & 1) << 3 | (i & 2) << 3 | (i & 1) << 6 | i << 8);
            fix <= 1'b1;
            @(posedge clk);
            fix <= 1'b0;
            take(8'h43);
            for (int k = 0; k < 4; k++)
                putw(mem[k], 4);
            putw(mem[4 + i / 2], 4);
            cmp("velocity");
            take(8'h4A);
            putw(mem[6], 4);
            putw(mem[7], 4);
            putw(mem[8 + i % 2], 4);
            putw(mem[10], 4);
            putw(mem[4 + i / 2], 4);
            cmp("position");
            chk("datum", dsel, i);
            chk("ref flag", ura, i % 2);
            rq(8'h2A);
            take(8'h4A);
            putw(mem[11], 4);
            putw(0, 4);
            e.push_back(8'(i % 2));
            cmp("ref alt");
        end
        for (int c = 3; c < 12; c += 7) begin
            wb(1, 10'h000, c > 8 ? 32'h21 : 32'h1);
            wb(1, 10'h00C, c);
            rq(8'h27);
            take(8'h47);
            n = c > 8 ? 8 : c;
            e.push_back(8'(n));
            for (int k = 0; k < n; k++) begin
                lv = mem[(c > 8 ? 26 : 25) + 3 * k];
                if (!mem[24 + 3 * k][9])
                    lv = 0;
                else
                    lv[31] = !mem[24 + 3 * k][8];
                e.push_back(mem[24 + 3 * k][7:0]);
                putw(lv, 4);
            end
            cmp("levels");
        end
        rq(8'h28);
        take(8'h48);
        for (int k = 15; k < 21; k++)
            putw(mem[k], k < 20 ? 4 : 2);
        cmp("message");
        ant <= 1'b1;
        bb <= 1'b1;
        @(posedge clk);
        ant <= 1'b0;
        bb <= 1'b0;
        for (int s = 0; s < 13; s++) begin
            if (s > 3 && s < 8)
                continue;
            wb(1, 10'h004, s);
            quiet();
            rq(8'h26);
            take(8'h46);
            chk("health", {p[0], p[1]}, {8'(s), 8'h11});
            take(8'h4B);
            chk("id", p[0], 8'h5A);
            chk("id len", p.size(), 3);
        end
        quiet();
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        take(8'h46);
        chk("soft reset len", p.size(), 2);
        take(8'h4B);
        quiet();
        rq(8'h26);
        take(8'h46);
        chk("soft reset", p[1], 0);
        chk("periodic", hcnt > 0, 1);
        conclude();
    end
endmodule : gpf_formatter_bench

// ==== bench/gpf_host_model.sv ====
// host side model: takes report bytes with random stalls
`timescale 1ns/1ps
module gpf_host_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic out_valid_i,
    input wire gpf_pkg::gpf_byte_type out_i,
    output logic out_ready_o
);
    gpf_pkg::gpf_byte_type got[$];
    int seed = 27185;

    initial out_ready_o = 1'b0;

    // host turns radians into degrees with the full-precision constant
    function automatic real rad_to_deg(input real r);
        rad_to_deg = r * 180.0 / 3.1415926535898;
    endfunction : rad_to_deg

    always @(posedge clk_i) begin
        if (out_valid_i && out_ready_o && !rst_i) begin
            got.push_back(out_i);
        end
        out_ready_o <= !rst_i && ($random(seed) % 4 != 0);
    end
endmodule : gpf_host_model

// ==== rtl/gpf_consts.svh ====
// offsets, field positions, reset values and timing for the report packet formatter
// What this block does
// RL1 - Cartesian velocity report after each fix when selected
// RL2 - time-of-fix in GPS time or UTC by option
// RL3 - version report at power-on and on request
// RL4 - ten version bytes, two processor groups of five
// RL5 - health report at power-on, soft reset, request, periodically
// RL6 - identification report always follows health report
// RL7 - status changes wait for next scheduled health report
// RL8 - health byte zero carries the status code
// RL9 - health byte one: memory and antenna fault bits
// RL10 - fault bits stay set until receiver reset
// RL11 - signal level report only on host request
// RL12 - count byte then up to eight number/level pairs
// RL13 - level sign shows lock, zero when never acquired
// RL14 - levels in amplitude units or dB-Hz by option
// RL15 - 22-byte system message on request, may be blank
// RL16 - 20-byte geodetic report after fix when selected
// RL17 - start-up geodetic report with negative time-of-fix
// RL18 - altitude from ellipsoid or sea-level geoid by option
// RL19 - datum selectable, default WGS-84
// RL20 - 9-byte reference altitude reply, flag at byte 8
// RL21 - altitude flag picks reference or held altitude
// RL22 - host converts radians with precise pi
// RL23 - floats and integers sent most significant byte first
`ifndef GPF_CONSTS_SVH
`define GPF_CONSTS_SVH

`define GPF_CLK_HZ 100000000
`define GPF_HEALTH_PERIOD_MS 5000

`define GPF_REG_CTRL 8'h00
`define GPF_REG_STATUS 8'h04
`define GPF_REG_STATE 8'h08
`define GPF_REG_SIGCNT 8'h0C
`define GPF_REG_IDSTAT 8'h10
`define GPF_MEM_SEL_BIT 8

`define GPF_CTRL_VEL_EARTH_CENTRED_CARTESIAN 0
`define GPF_CTRL_POS_LLA 1
`define GPF_CTRL_POS_DOUBLE 2
`define GPF_CTRL_ALT_MSL 3
`define GPF_CTRL_TIME_UTC 4
`define GPF_CTRL_DBHZ 5
`define GPF_CTRL_ALT_FLAG 6
`define GPF_CTRL_DATUM_LSB 8
`define GPF_CTRL_RESET 32'h0000_0001
`define GPF_DATUM_WGS84 8'h00

`define GPF_W_VX 6'h00
`define GPF_W_TOF_GPS 6'h04
`define GPF_W_TOF_UTC 6'h05
`define GPF_W_LAT 6'h06
`define GPF_W_LON 6'h07
`define GPF_W_ALT_HAE 6'h08
`define GPF_W_ALT_MSL 6'h09
`define GPF_W_CLKB 6'h0A
`define GPF_W_REFALT 6'h0B
`define GPF_W_VER 6'h0C
`define GPF_W_MSG 6'h0F
`define GPF_W_SAT 6'h18

`define GPF_FAULT_BATTERY_BACKED_MEMORY 0
`define GPF_FAULT_ANT 4

`define GPF_ID_VEL 8'h43
`define GPF_ID_VER 8'h45
`define GPF_ID_HLTH 8'h46
`define GPF_ID_SIG 8'h47
`define GPF_ID_MSG 8'h48
`define GPF_ID_POS 8'h4A
`define GPF_ID_MID 8'h4B
`define GPF_REQ_VER 8'h1F
`define GPF_REQ_HLTH 8'h26
`define GPF_REQ_SIG 8'h27
`define GPF_REQ_MSG 8'h28
`define GPF_REQ_REF 8'h2A

`define GPF_LEN_VEL 6'd20
`define GPF_LEN_VER 6'd10
`define GPF_LEN_HLTH 6'd2
`define GPF_LEN_MID 6'd3
`define GPF_LEN_MSG 6'd22
`define GPF_LEN_POS 6'd20
`define GPF_LEN_REF 6'd9
`define GPF_SIG_MAX 4'd8

`define GPF_PEND_POWERON 9'h08E

`endif

// ==== rtl/gpf_formatter.sv ====
// report packet scheduler and payload serialiser with wishbone registers
//
// The address map and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`include "gpf_consts.svh"
module gpf_formatter #(
    parameter int unsigned HEALTH_PERIOD_CYC = `GPF_HEALTH_PERIOD_MS * (`GPF_CLK_HZ / 1000),
    parameter logic [7:0] MACHINE_ID = 8'h5A  // arbitrary value
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic fix_done_i,
    input wire logic soft_reset_i,
    input wire logic req_valid_i,
    input wire logic [7:0] req_code_i,
    input wire logic battery_backed_memory_fail_i,
    input wire logic antenna_fault_i,
    input wire logic out_ready_i,
    output logic out_valid_o,
    output gpf_pkg::gpf_byte_type out_o,
    output logic [7:0] datum_sel_o,
    output logic use_ref_alt_o
);
    logic [31:0] ctrl;
    logic [7:0] status_code;
    logic [3:0] sig_count;
    logic [15:0] id_status;
    logic [31:0] fmem [0:63];
    logic [1:0] fault;
    logic [8:0] pend;
    logic [31:0] tick_cnt;
    logic tick;
    gpf_pkg::gpf_state_type state;
    gpf_pkg::gpf_kind_type kind;
    logic [5:0] idx;
    logic [2:0] pair;
    logic [2:0] off;
    logic done;

    logic wb_req;
    logic wb_wr;
    logic [31:0] wmask;
    logic [31:0] rd_val;
    logic req_ver;
    logic req_hlth;
    logic req_sig;
    logic req_msg;
    logic req_ref;
    logic [8:0] pend_set;
    logic have_pend;
    gpf_pkg::gpf_kind_type pick;
    gpf_pkg::gpf_kind_type q_kind;
    logic [5:0] q_idx;
    logic [2:0] q_pair;
    logic [2:0] q_off;
    logic [5:0] wsel;
    logic [31:0] wsh;
    logic [5:0] sat_base;
    logic [31:0] sat_ctrl;
    logic [31:0] sat_lvl;
    logic [31:0] lvl_sh;
    logic [7:0] byte_val;
    logic [5:0] len;
    logic [3:0] sig_n;
    logic start;
    logic adv;

    // wishbone slave: answer one cycle after the strobe
    assign wb_req = cyc_i && stb_i && !ack_o;
    // writes land at the edge where the master sees ack
    assign wb_wr = cyc_i && stb_i && we_i && ack_o;
    assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

    always_comb begin
        rd_val = 32'h0000_0000;
        if (adr_i[`GPF_MEM_SEL_BIT]) begin
            rd_val = fmem[adr_i[7:2]];
        end else begin
            case (adr_i[7:0])
                `GPF_REG_CTRL: rd_val = ctrl;
                `GPF_REG_STATUS: rd_val = {24'h000000, status_code};
                `GPF_REG_STATE: rd_val = {pend, 14'h0000, state == gpf_pkg::ST_SEND, 3'h0, fault[1], 3'h0, fault[0]};
                `GPF_REG_SIGCNT: rd_val = {28'h0000000, sig_count};
                `GPF_REG_IDSTAT: rd_val = {16'h0000, id_status};
                default: rd_val = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= wb_req;
            dat_o <= (wb_req && !we_i) ? rd_val : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= `GPF_CTRL_RESET;
            status_code <= 8'h01;
            sig_count <= 4'h0;
            id_status <= 16'h0000;
        end else if (wb_wr && !adr_i[`GPF_MEM_SEL_BIT]) begin
            case (adr_i[7:0])
                `GPF_REG_CTRL: ctrl <= (ctrl & ~wmask) | (dat_i & wmask);
                `GPF_REG_STATUS: if (sel_i[0]) status_code <= dat_i[7:0];  // RL8
                `GPF_REG_SIGCNT: if (sel_i[0]) sig_count <= dat_i[3:0];
                `GPF_REG_IDSTAT: id_status <= (id_status & ~wmask[15:0]) | (dat_i[15:0] & wmask[15:0]);
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 64; i++) begin
                fmem[i] <= 32'h0000_0000;
            end
        end else if (wb_wr && adr_i[`GPF_MEM_SEL_BIT]) begin
            fmem[adr_i[7:2]] <= (fmem[adr_i[7:2]] & ~wmask) | (dat_i & wmask);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            datum_sel_o <= `GPF_DATUM_WGS84;  // RL19
            use_ref_alt_o <= 1'b0;
        end else begin
            datum_sel_o <= ctrl[`GPF_CTRL_DATUM_LSB +: 8];  // RL19
            use_ref_alt_o <= ctrl[`GPF_CTRL_ALT_FLAG];  // RL21
        end
    end

    // sticky faults, new detection wins over soft reset clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault <= 2'b00;
        end else begin
            fault <= (soft_reset_i ? 2'b00 : fault) | {antenna_fault_i, battery_backed_memory_fail_i};  // RL10
        end
    end

    // periodic health tick
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_cnt <= 32'h0000_0000;
            tick <= 1'b0;
        end else begin
            tick <= (tick_cnt == HEALTH_PERIOD_CYC - 1);
            tick_cnt <= (tick_cnt == HEALTH_PERIOD_CYC - 1) ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
        end
    end

    // scheduling triggers
    assign req_ver = req_valid_i && req_code_i == `GPF_REQ_VER;
    assign req_hlth = req_valid_i && req_code_i == `GPF_REQ_HLTH;
    assign req_sig = req_valid_i && req_code_i == `GPF_REQ_SIG;
    assign req_msg = req_valid_i && req_code_i == `GPF_REQ_MSG;
    assign req_ref = req_valid_i && req_code_i == `GPF_REQ_REF;

    always_comb begin
        pend_set = 9'h000;
        pend_set[gpf_pkg::K_VEL] = fix_done_i && ctrl[`GPF_CTRL_VEL_EARTH_CENTRED_CARTESIAN];  // RL1
        pend_set[gpf_pkg::K_VER] = req_ver;  // RL3
        pend_set[gpf_pkg::K_HLTH] = tick || req_hlth || soft_reset_i;  // RL5 RL7
        pend_set[gpf_pkg::K_MID] = tick || req_hlth || soft_reset_i;  // RL6
        pend_set[gpf_pkg::K_SIG] = req_sig;  // RL11
        pend_set[gpf_pkg::K_MSG] = req_msg;  // RL15
        pend_set[gpf_pkg::K_POS] = fix_done_i && ctrl[`GPF_CTRL_POS_LLA] && !ctrl[`GPF_CTRL_POS_DOUBLE];  // RL16
        pend_set[gpf_pkg::K_REF] = req_ref;  // RL20
    end

    // power-on set includes the start-up position report
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend <= `GPF_PEND_POWERON;  // RL3 RL5 RL17
        end else begin
            pend <= (pend & ~(start ? (9'h001 << pick) : 9'h000)) | pend_set;
        end
    end

    always_comb begin
        pick = gpf_pkg::K_VEL;
        for (int i = 8; i >= 0; i--) begin
            if (pend[i]) begin
                pick = gpf_pkg::gpf_kind_type'(i[3:0]);
            end
        end
    end

    assign have_pend = |pend;
    assign start = state == gpf_pkg::ST_IDLE && have_pend;
    assign adv = state == gpf_pkg::ST_SEND && out_valid_o && out_ready_i;
    assign sig_n = (sig_count > `GPF_SIG_MAX) ? `GPF_SIG_MAX : sig_count;  // RL12

    always_comb begin
        case (q_kind)
            gpf_pkg::K_VEL: len = `GPF_LEN_VEL;
            gpf_pkg::K_VER: len = `GPF_LEN_VER;
            gpf_pkg::K_HLTH: len = `GPF_LEN_HLTH;
            gpf_pkg::K_MID: len = `GPF_LEN_MID;
            gpf_pkg::K_SIG: len = 6'(6'd1 + 6'(sig_n) * 6'd5);  // RL12
            gpf_pkg::K_MSG: len = `GPF_LEN_MSG;
            gpf_pkg::K_REF: len = `GPF_LEN_REF;
            default: len = `GPF_LEN_POS;
        endcase
    end

    assign done = adv && idx == len - 6'd1;

    // coordinates of the byte to load next
    always_comb begin
        q_kind = start ? pick : kind;
        q_idx = start ? 6'd0 : idx + 6'd1;
        q_pair = 3'd0;
        q_off = 3'd0;
        if (!start && idx != 6'd0) begin
            q_pair = (off == 3'd4) ? pair + 3'd1 : pair;
            q_off = (off == 3'd4) ? 3'd0 : off + 3'd1;
        end
    end

    // per-satellite level with lock sign and unit choice
    assign sat_base = 6'(`GPF_W_SAT + {2'b00, q_pair, 1'b0} + {3'b000, q_pair});
    assign sat_ctrl = fmem[sat_base];
    always_comb begin
        sat_lvl = fmem[sat_base + (ctrl[`GPF_CTRL_DBHZ] ? 6'd2 : 6'd1)];  // RL14
        if (!sat_ctrl[9]) begin
            sat_lvl = 32'h0000_0000;  // RL13
        end else begin
            sat_lvl = {!sat_ctrl[8], sat_lvl[30:0]};  // RL13
        end
    end
    assign lvl_sh = sat_lvl << {q_off[1:0] - 2'd1, 3'b000};

    // payload word selection, most significant byte first
    always_comb begin
        case (q_kind)
            gpf_pkg::K_VEL: wsel = (q_idx[4:2] == 3'd4)
                ? (ctrl[`GPF_CTRL_TIME_UTC] ? `GPF_W_TOF_UTC : `GPF_W_TOF_GPS)  // RL2
                : `GPF_W_VX + {3'b000, q_idx[4:2]};  // RL1
            gpf_pkg::K_VER: wsel = `GPF_W_VER + {3'b000, q_idx[4:2]};  // RL4
            gpf_pkg::K_MSG: wsel = `GPF_W_MSG + {3'b000, q_idx[4:2]};  // RL15
            gpf_pkg::K_REF: wsel = `GPF_W_REFALT;
            gpf_pkg::K_POS, gpf_pkg::K_SPOS: begin
                case (q_idx[4:2])
                    3'd0: wsel = `GPF_W_LAT;
                    3'd1: wsel = `GPF_W_LON;
                    3'd2: wsel = ctrl[`GPF_CTRL_ALT_MSL] ? `GPF_W_ALT_MSL : `GPF_W_ALT_HAE;  // RL18
                    3'd3: wsel = `GPF_W_CLKB;
                    default: wsel = ctrl[`GPF_CTRL_TIME_UTC] ? `GPF_W_TOF_UTC : `GPF_W_TOF_GPS;  // RL2
                endcase
            end
            default: wsel = `GPF_W_VX;
        endcase
    end
    assign wsh = fmem[wsel] << {q_idx[1:0], 3'b000};  // RL23

    always_comb begin
        byte_val = wsh[31:24];
        case (q_kind)
            gpf_pkg::K_HLTH: begin
                byte_val = 8'h00;
                if (q_idx == 6'd0) begin
                    byte_val = status_code;  // RL8
                end else begin
                    byte_val[`GPF_FAULT_BATTERY_BACKED_MEMORY] = fault[0];  // RL9
                    byte_val[`GPF_FAULT_ANT] = fault[1];  // RL9
                end
            end
            gpf_pkg::K_MID: begin
                case (q_idx[1:0])
                    2'd0: byte_val = MACHINE_ID;
                    2'd1: byte_val = id_status[7:0];
                    default: byte_val = id_status[15:8];
                endcase
            end
            gpf_pkg::K_SIG: begin
                if (q_idx == 6'd0) begin
                    byte_val = {4'h0, sig_n};  // RL12
                end else if (q_off == 3'd0) begin
                    byte_val = sat_ctrl[7:0];
                end else begin
                    byte_val = lvl_sh[31:24];  // RL23
                end
            end
            gpf_pkg::K_SPOS: begin
                if (q_idx == 6'd16) begin
                    byte_val = wsh[31:24] | 8'h80;  // RL17
                end
            end
            gpf_pkg::K_REF: begin
                if (q_idx == 6'd8) begin
                    byte_val = {7'h00, ctrl[`GPF_CTRL_ALT_FLAG]};  // RL20
                end else if (q_idx[4:2] != 3'd0) begin
                    byte_val = 8'h00;
                end
            end
            default: ;
        endcase
    end

    function automatic logic [7:0] kind_code(input gpf_pkg::gpf_kind_type k);
        case (k)
            gpf_pkg::K_VEL: kind_code = `GPF_ID_VEL;
            gpf_pkg::K_VER: kind_code = `GPF_ID_VER;
            gpf_pkg::K_HLTH: kind_code = `GPF_ID_HLTH;
            gpf_pkg::K_MID: kind_code = `GPF_ID_MID;
            gpf_pkg::K_SIG: kind_code = `GPF_ID_SIG;
            gpf_pkg::K_MSG: kind_code = `GPF_ID_MSG;
            default: kind_code = `GPF_ID_POS;
        endcase
    endfunction : kind_code

    // byte sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= gpf_pkg::ST_IDLE;
            kind <= gpf_pkg::K_VEL;
            idx <= 6'd0;
            pair <= 3'd0;
            off <= 3'd0;
            out_valid_o <= 1'b0;
            out_o <= '0;
        end else begin
            case (state)
                gpf_pkg::ST_IDLE: begin
                    if (start) begin
                        state <= gpf_pkg::ST_SEND;
                        kind <= pick;
                        idx <= 6'd0;
                        out_valid_o <= 1'b1;
                        out_o <= '{code: kind_code(pick), data: byte_val, first: 1'b1, last: len == 6'd1};
                    end
                end
                gpf_pkg::ST_SEND: begin
                    if (done) begin
                        state <= gpf_pkg::ST_IDLE;
                        out_valid_o <= 1'b0;
                        out_o <= '0;
                    end else if (adv) begin
                        idx <= q_idx;
                        pair <= q_pair;
                        off <= q_off;
                        out_o <= '{code: kind_code(kind), data: byte_val, first: 1'b0,
                                   last: q_idx == len - 6'd1};
                    end
                end
                default: state <= gpf_pkg::ST_IDLE;
            endcase
        end
    end

    fault_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)  // RL10
        fault[1] && !soft_reset_i |=> fault[1]) else $error("antenna fault bit dropped");
    vel_on_fix_a: assert property (@(posedge clk_i) disable iff (rst_i)  // RL1
        fix_done_i && ctrl[`GPF_CTRL_VEL_EARTH_CENTRED_CARTESIAN] |=> pend[gpf_pkg::K_VEL] || state == gpf_pkg::ST_SEND)
        else $error("velocity report not scheduled");
    sig_only_req_a: assert property (@(posedge clk_i) disable iff (rst_i)  // RL11
        $rose(pend[gpf_pkg::K_SIG]) |-> $past(req_sig)) else $error("signal report without request");
    health_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)  // RL7
        $rose(pend[gpf_pkg::K_HLTH]) |-> $past(tick || req_hlth || soft_reset_i))
        else $error("health report without schedule");
    health_pairs_id_a: assert property (@(posedge clk_i) disable iff (rst_i)  // RL6
        $rose(pend[gpf_pkg::K_HLTH]) |-> pend[gpf_pkg::K_MID]) else $error("id report missing");
    ver_length_a: assert property (@(posedge clk_i) disable iff (rst_i)  // RL4
        out_valid_o && out_o.last && kind == gpf_pkg::K_VER |-> idx == 6'd9) else $error("version length");
    ref_length_a: assert property (@(posedge clk_i) disable iff (rst_i)  // RL20
        out_valid_o && out_o.last && kind == gpf_pkg::K_REF |-> idx == 6'd8) else $error("ref altitude length");
    sig_length_a: assert property (@(posedge clk_i) disable iff (rst_i)  // RL12
        out_valid_o && out_o.last && kind == gpf_pkg::K_SIG |-> idx <= 6'd40) else $error("too many pairs");
    start_tof_neg_a: assert property (@(posedge clk_i) disable iff (rst_i)  // RL17
        out_valid_o && kind == gpf_pkg::K_SPOS && idx == 6'd16 |-> out_o.data[7]) else $error("start tof positive");
    byte_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)  // RL23
        out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_o)) else $error("byte changed while stalled");
    health_period_a: assert property (@(posedge clk_i) disable iff (rst_i)  // RL5
        tick |=> pend[gpf_pkg::K_HLTH] || state == gpf_pkg::ST_SEND) else $error("periodic health missed");
endmodule : gpf_formatter

// ==== rtl/gpf_pkg.sv ====
// types for the report packet formatter
package gpf_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SEND = 2'b10
    } gpf_state_type;

    // pending bit order is also send priority
    typedef enum logic [3:0] {
        K_VEL = 4'h0,
        K_VER = 4'h1,
        K_HLTH = 4'h2,
        K_MID = 4'h3,
        K_SIG = 4'h4,
        K_MSG = 4'h5,
        K_POS = 4'h6,
        K_SPOS = 4'h7,
        K_REF = 4'h8
    } gpf_kind_type;

    typedef struct packed {
        logic [7:0] code;
        logic [7:0] data;
        logic first;
        logic last;
    } gpf_byte_type;
endpackage : gpf_pkg
